// *** design/memory_io_glue_logic.sv ***
`timescale 1ns/1ps
// How it works
// RULE1 - A counter divides the 16 MHz oscillator enable by four to make the 4 MHz system clock.
// RULE2 - After reset the map latch selects the boot map with ROM reachable by the CPU.
// RULE3 - In the boot map ROM lies at 0 to 4K and scratch RAM at 4K to 5K.
// RULE4 - An output cycle to port 04H switches the whole 64K space to DRAM.
// RULE5 - A ROM or scratch RAM access gets exactly one wait cycle.
// RULE6 - The 16 address lines are multiplexed into row then column halves under the strobes.
// RULE7 - Refresh is a row-strobe-only cycle over 128 rows.
// RULE8 - A fetch cycle with the refresh strobe runs a refresh using the CPU row address.
// RULE9 - The DMA master must release the buses within two ms since no refresh runs meanwhile.
// RULE10 - I/O decode picks switches at 00H, map latch at 04H and DMA at 10H.
// RULE11 - Timer channels 0 to 3 decode at ports 08H to 0BH.
// RULE12 - Serial A data/command at 0CH/0EH and serial B data/command at 0DH/0FH.
// RULE13 - The interrupt chain orders DMA first, serial second, timer third.
// RULE14 - Once in the all-DRAM map the latch holds until reset and ignores the data.
module memory_io_glue_logic (
  // Clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // CPU bus
  input  wire logic [15:0]                addr_in,
  input  wire glue_pkg::cpu_ctl_t         cpu_ctl_in,
  input  wire logic [glue_pkg::OPT_BITS-1:0] option_switch_in,
  // Interrupt pending flags from the DMA and serial devices, active high
  input  wire logic                       dma_int_pending_in,
  input  wire logic                       ser_int_pending_in,
  // System clock enable and wait
  output logic                            sys_clk_en_out,
  output logic                            wait_n_out,
  // Switch read data, drives data bus when enable low
  output logic [7:0]                      switch_data_out,
  output logic                            switch_data_oe_n_out,
  // Memory and device selects
  output glue_pkg::sel_t                  sel_out,
  output logic                            all_dram_map_out,
  // DRAM
  output logic [7:0]                      dram_addr_out,
  output logic                            row_strobe_n_out,
  output logic                            col_strobe_n_out,
  output logic                            dram_we_n_out,
  // Interrupt daisy chain enables into serial and timer chips
  output logic                            ser_int_enable_out,
  output logic                            timer_int_enable_out
);

  // Input synchronisers, three stages; change counts when stage 2 and 3 agree
  localparam int NSYNC = 16 + 7 + glue_pkg::OPT_BITS + 2;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] stable;
  // Idle bus levels, so no false strobe follows reset
  localparam logic [NSYNC-1:0] IDLE_IN = {16'h0000, 7'h7F,
                                          {glue_pkg::OPT_BITS{1'b0}}, 2'b00};

  assign raw_in = {addr_in, cpu_ctl_in, option_switch_in, dma_int_pending_in,
                   ser_int_pending_in};

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1 <= IDLE_IN;
      s2 <= IDLE_IN;
      s3 <= IDLE_IN;
    end
    else
    begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_filt
      always_ff @(posedge ref_clk_in or posedge rst_in)
      begin
        if (rst_in)
          stable[gi] <= IDLE_IN[gi];
        else if (s2[gi] == s3[gi])
          stable[gi] <= s3[gi];
      end
    end
  endgenerate

  logic [15:0]                  addr;
  glue_pkg::cpu_ctl_t           ctl;
  logic [glue_pkg::OPT_BITS-1:0] opts;
  logic                         dma_pend;
  logic                         ser_pend;
  assign {addr, ctl, opts, dma_pend, ser_pend} = stable;

  // Oscillator enable from ref clock, then divide by four
  localparam int OCW = $clog2(glue_pkg::OSC_CYCLES + 1);
  logic [OCW-1:0] osc_cnt;
  logic [1:0]     div_cnt;
  wire            osc_tick = (osc_cnt == OCW'(glue_pkg::OSC_CYCLES - 1));
  wire            next_sys = osc_tick && (div_cnt == 2'(glue_pkg::DIV_RATIO - 1));

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      osc_cnt        <= '0;
      div_cnt        <= '0;
      sys_clk_en_out <= 1'b0;
    end
    else
    begin
      osc_cnt        <= osc_tick ? '0 : osc_cnt + OCW'(1);
      if (osc_tick)
        div_cnt      <= div_cnt + 2'd1; // [RULE1]
      sys_clk_en_out <= next_sys; // [RULE1]
    end
  end

  // Address and I/O decode
  function automatic logic io_hit(input logic [7:0] a, input logic [7:0] port);
    return a == port;
  endfunction

  logic all_dram;
  wire  mem_cyc   = !ctl.memory_request_n && ctl.refresh_strobe_n && ctl.bus_grant_n;
  wire  mem_any   = !ctl.memory_request_n && ctl.refresh_strobe_n;
  wire  io_cyc    = !ctl.io_request_n && ctl.fetch_cycle_n;
  wire  rom_hit   = !all_dram && addr < glue_pkg::ROM_TOP; // [RULE2] [RULE3]
  wire  sram_hit  = !all_dram && addr >= glue_pkg::ROM_TOP
                    && addr < glue_pkg::SRAM_TOP; // [RULE3]
  wire  slow_acc  = mem_any && (rom_hit || sram_hit);
  wire  latch_wr  = io_cyc && !ctl.wr_n && io_hit(addr[7:0], glue_pkg::PORT_MAP_LATCH); // [RULE4]

  glue_pkg::sel_t next_sel;
  always_comb
  begin
    next_sel            = '0;
    next_sel.rom        = mem_any && rom_hit;
    next_sel.sram       = mem_any && sram_hit;
    next_sel.dram       = mem_any && !rom_hit && !sram_hit; // [RULE4]
    next_sel.switch_rd  = io_cyc && !ctl.rd_n
                          && io_hit(addr[7:0], glue_pkg::PORT_SWITCH); // [RULE10]
    next_sel.dma        = io_cyc && io_hit(addr[7:0], glue_pkg::PORT_DMA); // [RULE10]
    for (int i = 0; i < 4; i++)
      next_sel.timer[i] = io_cyc
        && io_hit(addr[7:0], glue_pkg::PORT_TIMER_BASE + 8'(i)); // [RULE11]
    next_sel.ser_a_data = io_cyc && io_hit(addr[7:0], glue_pkg::PORT_SER_A_DATA); // [RULE12]
    next_sel.ser_a_cmd  = io_cyc && io_hit(addr[7:0], glue_pkg::PORT_SER_A_CMD); // [RULE12]
    next_sel.ser_b_data = io_cyc && io_hit(addr[7:0], glue_pkg::PORT_SER_B_DATA); // [RULE12]
    next_sel.ser_b_cmd  = io_cyc && io_hit(addr[7:0], glue_pkg::PORT_SER_B_CMD); // [RULE12]
  end

  // Map latch: set once, held to reset, data ignored
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      all_dram <= 1'b0; // [RULE2]
    else if (latch_wr)
      all_dram <= 1'b1; // [RULE4] [RULE14]
  end

  // Wait: one system clock of wait per slow access
  logic slow_seen;
  logic wait_done;
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      slow_seen  <= 1'b0;
      wait_done  <= 1'b0;
      wait_n_out <= 1'b1;
    end
    else if (!slow_acc)
    begin
      slow_seen  <= 1'b0;
      wait_done  <= 1'b0;
      wait_n_out <= 1'b1;
    end
    else if (sys_clk_en_out)
    begin
      slow_seen  <= 1'b1;
      wait_done  <= slow_seen;
      wait_n_out <= !(!slow_seen && !wait_done); // [RULE5]
    end
  end

  // DRAM control: row then column strobe; refresh is row strobe only
  typedef enum logic [1:0] {D_IDLE, D_ROW, D_COL, D_REF} dram_st_t;
  dram_st_t dst;
  dram_st_t next_dst;
  wire dram_req = mem_cyc && !rom_hit && !sram_hit;
  wire ref_req  = !ctl.memory_request_n && !ctl.refresh_strobe_n; // [RULE8]

  always_comb
  begin
    case (dst)
      D_IDLE:  next_dst = ref_req ? D_REF : (dram_req ? D_ROW : D_IDLE);
      D_ROW:   next_dst = dram_req ? D_COL : D_IDLE;
      D_COL:   next_dst = dram_req ? D_COL : D_IDLE;
      D_REF:   next_dst = ref_req ? D_REF : D_IDLE;
      default: next_dst = D_IDLE;
    endcase
  end

  wire [7:0] next_dram_addr = (next_dst == D_REF) ? {1'b0, addr[6:0]} : // [RULE7] [RULE8]
                              (next_dst == D_COL) ? addr[15:8] : addr[7:0]; // [RULE6]

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dst              <= D_IDLE;
      dram_addr_out    <= '0;
      row_strobe_n_out <= 1'b1;
      col_strobe_n_out <= 1'b1;
      dram_we_n_out    <= 1'b1;
    end
    else
    begin
      dst              <= next_dst;
      dram_addr_out    <= next_dram_addr; // [RULE6]
      row_strobe_n_out <= !(next_dst == D_ROW || next_dst == D_COL
                            || next_dst == D_REF); // [RULE7]
      col_strobe_n_out <= !(next_dst == D_COL); // [RULE6] [RULE7]
      dram_we_n_out    <= !(next_dst == D_COL && !ctl.wr_n);
    end
  end

  // Registered selects, switch read, interrupt chain
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_out              <= '0;
      all_dram_map_out     <= 1'b0;
      switch_data_out      <= '0;
      switch_data_oe_n_out <= 1'b1;
      ser_int_enable_out   <= 1'b1;
      timer_int_enable_out <= 1'b1;
    end
    else
    begin
      sel_out              <= next_sel;
      all_dram_map_out     <= all_dram;
      switch_data_out      <= {{(8 - glue_pkg::OPT_BITS){1'b0}}, opts};
      switch_data_oe_n_out <= !next_sel.switch_rd; // [RULE10]
      ser_int_enable_out   <= !dma_pend; // [RULE13]
      timer_int_enable_out <= !dma_pend && !ser_pend; // [RULE13]
    end
  end

  // Checks
  property p_latch_sticky;
    @(posedge ref_clk_in) disable iff (rst_in)
    all_dram |=> all_dram;
  endproperty
  a_latch_sticky: assert property (p_latch_sticky) // [RULE14]
    else $error("map latch dropped");

  property p_latch_set;
    @(posedge ref_clk_in) disable iff (rst_in)
    latch_wr |=> ##1 all_dram_map_out;
  endproperty
  a_latch_set: assert property (p_latch_set) // [RULE4]
    else $error("map latch not set by port write");

  property p_boot_rom;
    @(posedge ref_clk_in) disable iff (rst_in)
    (!all_dram && mem_any && addr < glue_pkg::ROM_TOP) |=> sel_out.rom;
  endproperty
  a_boot_rom: assert property (p_boot_rom) // [RULE3]
    else $error("rom not selected in boot map");

  property p_no_rom_after;
    @(posedge ref_clk_in) disable iff (rst_in)
    $past(all_dram) |-> !sel_out.rom && !sel_out.sram;
  endproperty
  a_no_rom_after: assert property (p_no_rom_after) // [RULE4]
    else $error("slow memory selected in dram map");

  property p_ref_col_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
    (dst == D_REF) |-> col_strobe_n_out && !row_strobe_n_out;
  endproperty
  a_ref_col_quiet: assert property (p_ref_col_quiet) // [RULE7]
    else $error("column strobe during refresh");

  property p_div;
    @(posedge ref_clk_in) disable iff (rst_in)
    osc_tick && div_cnt == 2'd3 |=> sys_clk_en_out ##1 !sys_clk_en_out;
  endproperty
  a_div: assert property (p_div) // [RULE1]
    else $error("system clock enable wrong");

  property p_prio;
    @(posedge ref_clk_in) disable iff (rst_in)
    dma_pend |=> !ser_int_enable_out && !timer_int_enable_out;
  endproperty
  a_prio: assert property (p_prio) // [RULE13]
    else $error("daisy chain order broken");

  property p_io_dma;
    @(posedge ref_clk_in) disable iff (rst_in)
    (io_cyc && addr[7:0] == glue_pkg::PORT_DMA) |=> sel_out.dma && sel_out.timer == 4'h0;
  endproperty
  a_io_dma: assert property (p_io_dma) // [RULE10] [RULE11]
    else $error("dma port decode wrong");

endmodule

// *** design/glue_pkg.sv ***
package glue_pkg;
  // Oscillator 16 MHz divided to 4 MHz system clock
  localparam int          OSC_MHZ          = 16;
  localparam int          SYS_MHZ          = 4;
  localparam int          DIV_RATIO        = OSC_MHZ / SYS_MHZ;
  // Reference clock 40 MHz, period 25 ns
  localparam int          REF_PERIOD_PS    = 25000;
  // Oscillator emulated by ref clock: one 16 MHz period in ref cycles (rounded down)
  localparam int          OSC_PERIOD_PS    = 1000000 / OSC_MHZ;
  localparam int          OSC_CYCLES       = (OSC_PERIOD_PS / REF_PERIOD_PS) < 1 ? 1 :
                                             OSC_PERIOD_PS / REF_PERIOD_PS;
  // Refresh: 128 rows every two ms
  localparam int          REFRESH_ROWS     = 128;
  localparam int          REFRESH_MS       = 2;
  // Memory map top addresses in bytes
  localparam logic [15:0] ROM_TOP          = 16'h1000;
  localparam logic [15:0] SRAM_TOP         = 16'h1400;
  // I/O ports
  localparam logic [7:0]  PORT_SWITCH      = 8'h00;
  localparam logic [7:0]  PORT_MAP_LATCH   = 8'h04;
  localparam logic [7:0]  PORT_TIMER_BASE  = 8'h08;
  localparam logic [7:0]  PORT_SER_A_DATA  = 8'h0C;
  localparam logic [7:0]  PORT_SER_B_DATA  = 8'h0D;
  localparam logic [7:0]  PORT_SER_A_CMD   = 8'h0E;
  localparam logic [7:0]  PORT_SER_B_CMD   = 8'h0F;
  localparam logic [7:0]  PORT_DMA         = 8'h10;
  localparam int          OPT_BITS         = 4;
  localparam int          WAIT_CYCLES      = 1;

  // CPU bus strobes, all active low
  typedef struct packed {
    logic memory_request_n;
    logic io_request_n;
    logic rd_n;
    logic wr_n;
    logic refresh_strobe_n;
    logic fetch_cycle_n;
    logic bus_grant_n;
  } cpu_ctl_t;

  // Device selects, active high
  typedef struct packed {
    logic rom;
    logic sram;
    logic dram;
    logic switch_rd;
    logic dma;
    logic [3:0] timer;
    logic ser_a_data;
    logic ser_a_cmd;
    logic ser_b_data;
    logic ser_b_cmd;
  } sel_t;
endpackage

// *** verif/cpu_bus_model.sv ***
`timescale 1ns/1ps
module cpu_bus_model (
  // Bus driven toward the glue logic
  output logic [15:0]        addr_out,
  output glue_pkg::cpu_ctl_t ctl_out
);
  initial
  begin
    addr_out = 16'h0000;
    ctl_out  = 7'h7F;
  end
  // Start a machine cycle; called just after a falling edge
  task automatic start(input logic [6:0] ctl, input logic [15:0] addr);
  begin
    addr_out = addr;
    ctl_out  = ctl;
  end
  endtask
  // Released address shows the inverse of its last value
  task automatic stop();
  begin
    ctl_out  = 7'h7F;
    addr_out = ~addr_out;
  end
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic               ref_clk_in, rst_in, dma_int_pending_in, ser_int_pending_in;
  logic [3:0]         option_switch_in;
  logic [15:0]        addr;
  glue_pkg::cpu_ctl_t ctl;
  logic               sys_clk_en_out, wait_n_out, switch_data_oe_n_out, all_dram_map_out;
  logic [7:0]         switch_data_out, dram_addr_out;
  logic               row_strobe_n_out, col_strobe_n_out, dram_we_n_out;
  logic               ser_int_enable_out, timer_int_enable_out;
  glue_pkg::sel_t     sel_out, e;
  int                 miscompares, checked, cycles;
  logic [15:0]        n;
  cpu_bus_model cpu (.addr_out(addr), .ctl_out(ctl));
  memory_io_glue_logic DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr),
    .cpu_ctl_in(ctl), .option_switch_in(option_switch_in),
    .dma_int_pending_in(dma_int_pending_in), .ser_int_pending_in(ser_int_pending_in),
    .sys_clk_en_out(sys_clk_en_out), .wait_n_out(wait_n_out),
    .switch_data_out(switch_data_out), .switch_data_oe_n_out(switch_data_oe_n_out),
    .sel_out(sel_out), .all_dram_map_out(all_dram_map_out), .dram_addr_out(dram_addr_out),
    .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
    .dram_we_n_out(dram_we_n_out), .ser_int_enable_out(ser_int_enable_out),
    .timer_int_enable_out(timer_int_enable_out));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task automatic give_verdict();
  begin
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic t_clock();
  begin
    n = 0;
    repeat (80) @(negedge ref_clk_in) n += sys_clk_en_out;
    chk(n, 16'(80 / (glue_pkg::DIV_RATIO * glue_pkg::OSC_CYCLES)));
    $display("clock done");
  end
  endtask
  task automatic t_boot();
    logic [15:0] a [4] = '{16'h0FFF, 16'h1000, 16'h13FF, 16'h1400};
  begin
    foreach (a[i])
    begin
      e = '0;
      e.rom = (a[i] < glue_pkg::ROM_TOP);
      e.sram = !e.rom && (a[i] < glue_pkg::SRAM_TOP);
      e.dram = !e.rom && !e.sram;
      cpu.start(7'h2F, a[i]);
      n = 0;
      repeat (40) @(negedge ref_clk_in) n += !wait_n_out;
      chk(sel_out, e);
      chk(n, e.dram ? 16'h0000 : 16'(glue_pkg::DIV_RATIO * glue_pkg::OSC_CYCLES));
      cpu.stop();
      cyc(8);
    end
    $display("boot map done");
  end
  endtask
  task automatic t_io();
    logic [7:0] p [10] = '{8'h00, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
  begin
    foreach (p[i])
    begin
      e = '0;
      e.switch_rd = (p[i] == 8'h00);
      e.dma = (p[i] == 8'h10);
      e.ser_a_data = (p[i] == 8'h0C);
      e.ser_b_data = (p[i] == 8'h0D);
      e.ser_a_cmd = (p[i] == 8'h0E);
      e.ser_b_cmd = (p[i] == 8'h0F);
      if (p[i] >= 8'h08 && p[i] <= 8'h0B)
        e.timer[p[i] - 8'h08] = 1'b1;
      cpu.start(7'h4F, {8'hA5, p[i]});
      cyc(10);
      chk(sel_out, e);
      if (p[i] == 8'h00)
        chk({switch_data_oe_n_out, switch_data_out}, 9'h00A);
      cpu.stop();
      cyc(8);
    end
    $display("io decode done");
  end
  endtask
  task automatic t_refresh();
  begin
    cpu.start(7'h3B, 16'hC3D5);
    for (int i = 0; i < 20 && row_strobe_n_out !== 1'b0; i++) cyc(1);
    chk({row_strobe_n_out, dram_addr_out}, 9'h055);
    n = 0;
    repeat (8) @(negedge ref_clk_in) n += !col_strobe_n_out;
    chk(n, 0);
    cpu.stop();
    cyc(8);
    $display("refresh done");
  end
  endtask
  task automatic t_map();
  begin
    repeat (2)
    begin
      cpu.start(7'h57, 16'h3304);
      cyc(8);
      cpu.stop();
      cyc(8);
      chk(all_dram_map_out, 1'b1);
    end
    e = '0;
    e.dram = 1'b1;
    cpu.start(7'h2F, 16'h0123);
    for (int i = 0; i < 20 && row_strobe_n_out !== 1'b0; i++) cyc(1);
    chk({row_strobe_n_out, col_strobe_n_out, dram_addr_out}, 10'h123);
    for (int i = 0; i < 20 && col_strobe_n_out !== 1'b0; i++) cyc(1);
    chk({row_strobe_n_out, col_strobe_n_out, dram_we_n_out, dram_addr_out}, 11'h101);
    cyc(4);
    chk({sel_out, wait_n_out}, {e, 1'b1});
    cpu.stop();
    cyc(8);
    // DRAM write: write strobe low with the column strobe
    cpu.start(7'h37, 16'h4567);
    for (int i = 0; i < 20 && col_strobe_n_out !== 1'b0; i++) cyc(1);
    chk({row_strobe_n_out, col_strobe_n_out, dram_we_n_out, dram_addr_out}, 11'h045);
    cpu.stop();
    cyc(8);
    $display("map switch done");
  end
  endtask
  task automatic t_chain();
  begin
    dma_int_pending_in = 1'b1;
    cyc(8);
    chk({ser_int_enable_out, timer_int_enable_out}, 2'b00);
    dma_int_pending_in = 1'b0;
    ser_int_pending_in = 1'b1;
    cyc(8);
    chk({ser_int_enable_out, timer_int_enable_out}, 2'b10);
    ser_int_pending_in = 1'b0;
    cyc(8);
    chk({ser_int_enable_out, timer_int_enable_out}, 2'b11);
    $display("chain done");
  end
  endtask
  initial
  begin
    miscompares = 0;
    checked = 0;
    cycles = 0;
    rst_in = 1'b1;
    dma_int_pending_in = 1'b0;
    ser_int_pending_in = 1'b0;
    option_switch_in = 4'hA;
    cyc(5);
    rst_in = 1'b0;
    chk({sel_out, all_dram_map_out, wait_n_out}, 15'h0001);
    cyc(2);
    t_clock();
    t_boot();
    t_io();
    t_refresh();
    t_map();
    t_chain();
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    cyc(8);
    chk(all_dram_map_out, 1'b0);
    give_verdict();
  end
endmodule
